// ===== src/rfa_bank.sv
// register bank showing each field access type on a simple bus port
// assumes a single-cycle master; read data valid the cycle after rd_en
//
// What this block does
// - clear-on-read field returns its value, then hardware clears it.
// - read-write field stores writes and returns the last written value.
// - readable clear-on-write field clears on any write, stays readable.
// - write-one-to-clear: ones clear bits, zeros keep bits unchanged.
// - writing back a read status clears only those bits; new stay pending.
// - writing zero to a write-one-to-set bit leaves it unchanged.
// - write-only clear register: ones clear matching interrupt bits.
// - reading the write-only clear register yields no meaningful data.
// - reserved bits read as zero; software must not rely on them.
// - registers decode at their offset added to the module base.
`timescale 1ns/1ps
`include "rfa_regs.svh"

module rfa_bank #(
  parameter logic [31:0] BASE_ADDR = 32'h4000_0000,
  parameter int          EV_W      = 8
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // register access port
  input  wire logic [31:0]         addr,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire rfa_pkg::rfa_word_t  wr_data,
  output logic                     rd_valid,
  output rfa_pkg::rfa_word_t       rd_data,
  output logic                     addr_err,
  // peripheral side
  input  wire logic [7:0]          hw_status,
  input  wire logic                hw_count_inc,
  input  wire logic [EV_W-1:0]     hw_error,
  input  wire logic [EV_W-1:0]     hw_event,
  output logic [31:0]              ctrl_out,
  output logic [EV_W-1:0]          set_req_out,
  output logic [EV_W-1:0]          pending_out
);
  import rfa_pkg::*;

  // all-ones field, used for a clear by any write
  localparam logic [EV_W-1:0] EV_ALL = {EV_W{1'b1}};

  // field storage
  rfa_word_t       ctrl_reg;
  logic [15:0]     evcount_reg;
  logic [EV_W-1:0] errlog_reg;
  logic [EV_W-1:0] ris_reg;
  logic [EV_W-1:0] setreq_reg;
  // decoded strobes
  rfa_sel_t        sel;
  logic            wr_hit;
  logic            rd_hit;
  logic            rd_take;
  logic            acc_miss;
  logic            wr_ctrl;
  logic            wr_errlog;
  logic            wr_ris;
  logic            wr_iclr;
  logic            wr_setreq;
  logic            rd_evcount;
  // read path
  rfa_word_t       rd_word;

  // offset relative to the module base; out of window gives none
  function automatic rfa_sel_t decode(input logic [31:0] a);
    logic [31:0] rel;
    rel = a - BASE_ADDR;
    decode = RFA_SEL_NONE;
    if (rel[31:12] == 20'h00000) begin
      case (rel[11:0])
        `RFA_OFF_CTRL: begin
          decode = RFA_SEL_CTRL;
        end
        `RFA_OFF_STATUS: begin
          decode = RFA_SEL_STATUS;
        end
        `RFA_OFF_EVCOUNT: begin
          decode = RFA_SEL_EVCOUNT;
        end
        `RFA_OFF_ERRLOG: begin
          decode = RFA_SEL_ERRLOG;
        end
        `RFA_OFF_RIS: begin
          decode = RFA_SEL_RIS;
        end
        `RFA_OFF_SETREQ: begin
          decode = RFA_SEL_SETREQ;
        end
        `RFA_OFF_ICLR: begin
          decode = RFA_SEL_ICLR;
        end
        default: begin
          decode = RFA_SEL_NONE;
        end
      endcase
    end
  endfunction

  // widen a field into a bus word, reserved bits zero
  function automatic rfa_word_t widen(input logic [31:0] v,
                                      input logic [31:0] m);
    widen = v & m;
  endfunction

  // clear written ones; new events win over the clear
  function automatic logic [EV_W-1:0] clear_ones(
      input logic [EV_W-1:0] cur,
      input logic [EV_W-1:0] ones,
      input logic [EV_W-1:0] ev);
    clear_ones = (cur & ~ones) | ev;
  endfunction

  // set written ones; zero bits leave the field alone
  function automatic logic [EV_W-1:0] set_ones(
      input logic [EV_W-1:0] cur,
      input logic [EV_W-1:0] ones);
    set_ones = cur | ones;
  endfunction

  // counter step, wraps at the field width
  function automatic logic [15:0] count_step(
      input logic [15:0] cur,
      input logic        up);
    count_step = up ? cur + 16'h0001 : cur;
  endfunction

  // strobe for one register select
  function automatic logic strobe_at(
      input rfa_sel_t s,
      input rfa_sel_t want,
      input logic     go);
    strobe_at = go && (s == want);
  endfunction

  always_comb begin
    sel        = decode(addr);
    wr_hit     = wr_en && (sel != RFA_SEL_NONE);
    rd_take    = rd_en && !wr_en;
    rd_hit     = rd_take && (sel != RFA_SEL_NONE);
    acc_miss   = (rd_en || wr_en) && (sel == RFA_SEL_NONE);
    wr_ctrl    = strobe_at(sel, RFA_SEL_CTRL, wr_hit);
    wr_errlog  = strobe_at(sel, RFA_SEL_ERRLOG, wr_hit);
    wr_ris     = strobe_at(sel, RFA_SEL_RIS, wr_hit);
    wr_iclr    = strobe_at(sel, RFA_SEL_ICLR, wr_hit);
    wr_setreq  = strobe_at(sel, RFA_SEL_SETREQ, wr_hit);
    rd_evcount = strobe_at(sel, RFA_SEL_EVCOUNT, rd_hit);
  end

  // read-write control
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= `RFA_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_reg <= wr_data & `RFA_MASK_CTRL;
    end
  end

  // clear-on-read event counter; increment in the read cycle is kept
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      evcount_reg <= `RFA_RST_EVCOUNT;
    end else if (rd_evcount) begin
      evcount_reg <= count_step(16'h0000, hw_count_inc);
    end else begin
      evcount_reg <= count_step(evcount_reg, hw_count_inc);
    end
  end

  // error log: any write clears, new error in same cycle wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      errlog_reg <= EV_W'(`RFA_RST_ERRLOG);
    end else if (wr_errlog) begin
      errlog_reg <= clear_ones(errlog_reg, EV_ALL, hw_error);
    end else begin
      errlog_reg <= set_ones(errlog_reg, hw_error);
    end
  end

  // raw interrupt status, cleared by w1c here or by the write-only alias
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ris_reg <= EV_W'(`RFA_RST_RIS);
    end else if (wr_ris || wr_iclr) begin
      ris_reg <= clear_ones(ris_reg, wr_data[EV_W-1:0],
                            hw_event);
    end else begin
      ris_reg <= set_ones(ris_reg, hw_event);
    end
  end

  // write-one-to-set request bits, consumed by no hardware clear here
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      setreq_reg <= EV_W'(`RFA_RST_SETREQ);
    end else if (wr_setreq) begin
      setreq_reg <= set_ones(setreq_reg, wr_data[EV_W-1:0]);
    end
  end

  // read mux; status writes are dropped, unmapped reads give zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (sel)
      RFA_SEL_CTRL: begin
        rd_word = widen(ctrl_reg, `RFA_MASK_CTRL);
      end
      RFA_SEL_STATUS: begin
        rd_word = widen({24'h000000, hw_status}, `RFA_MASK_STATUS);
      end
      RFA_SEL_EVCOUNT: begin
        rd_word = widen({16'h0000, evcount_reg}, `RFA_MASK_EVCOUNT);
      end
      RFA_SEL_ERRLOG: begin
        rd_word = widen(32'(errlog_reg), `RFA_MASK_ERRLOG);
      end
      RFA_SEL_RIS: begin
        rd_word = widen(32'(ris_reg), `RFA_MASK_RIS);
      end
      RFA_SEL_SETREQ: begin
        rd_word = widen(32'(setreq_reg), `RFA_MASK_SETREQ);
      end
      RFA_SEL_ICLR: begin
        rd_word = 32'h0000_0000;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // one-cycle answer to every read strobe not paired with wr_en
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_take;
    end
  end

  // pulse for an access that hits no register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_err <= 1'b0;
    end else begin
      addr_err <= acc_miss;
    end
  end

  // read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_take) begin
      rd_data <= rd_word;
    end
  end

  always_comb begin
    ctrl_out    = ctrl_reg;
    set_req_out = setreq_reg;
    pending_out = ris_reg;
  end
endmodule

// ===== src/rfa_regs.svh
// register bank offsets, field layout and reset values
// assumes word-aligned 32-bit accesses relative to a module base address
`ifndef RFA_REGS_SVH
`define RFA_REGS_SVH

// register offsets from the module base
`define RFA_OFF_CTRL      12'h000
`define RFA_OFF_STATUS    12'h004
`define RFA_OFF_EVCOUNT   12'h008
`define RFA_OFF_ERRLOG    12'h00c
`define RFA_OFF_RIS       12'h010
`define RFA_OFF_SETREQ    12'h014
`define RFA_OFF_ICLR      12'h018

// implemented bit masks; other bits are reserved and read as zero
`define RFA_MASK_CTRL     32'h0000_ffff
`define RFA_MASK_STATUS   32'h0000_00ff
`define RFA_MASK_EVCOUNT  32'h0000_ffff
`define RFA_MASK_ERRLOG   32'h0000_00ff
`define RFA_MASK_RIS      32'h0000_00ff
`define RFA_MASK_SETREQ   32'h0000_00ff

// reset values
`define RFA_RST_CTRL      32'h0000_0000
`define RFA_RST_EVCOUNT   16'h0000
`define RFA_RST_ERRLOG    8'h00
`define RFA_RST_RIS       8'h00
`define RFA_RST_SETREQ    8'h00

`endif

// ===== src/rfa_pkg.sv
// types for the register field access bank
// assumes rfa_regs.svh supplies the numeric constants
package rfa_pkg;
  typedef logic [31:0] rfa_word_t;
  typedef logic [11:0] rfa_off_t;
  typedef enum logic [2:0] {
    RFA_SEL_NONE    = 3'h0,
    RFA_SEL_CTRL    = 3'h1,
    RFA_SEL_STATUS  = 3'h3,
    RFA_SEL_EVCOUNT = 3'h2,
    RFA_SEL_ERRLOG  = 3'h6,
    RFA_SEL_RIS     = 3'h7,
    RFA_SEL_SETREQ  = 3'h5,
    RFA_SEL_ICLR    = 3'h4
  } rfa_sel_t;
endpackage

// ===== bench/rfa_bank_chk.sv
// port checker for rfa_bank
// assumes it is bound into every rfa_bank
`timescale 1ns/1ps
`include "rfa_regs.svh"
module rfa_chk #(
  parameter logic [31:0] BASE_ADDR = 32'h4000_0000,
  parameter int          EV_W      = 8
) (
  input wire logic               ref_clk, reset, wr_en, rd_en,
  input wire logic               rd_valid, addr_err,
  input wire logic [31:0]        addr, ctrl_out,
  input wire rfa_pkg::rfa_word_t wr_data, rd_data,
  input wire logic [7:0]         hw_status,
  input wire logic [EV_W-1:0]    hw_event, set_req_out, pending_out
);
  import rfa_pkg::*;
  wire logic [31:0] off = addr - BASE_ADDR;
  wire logic map = off < 32'h1c && off[1:0] == 2'h0;
  wire logic r = rd_en && !wr_en;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rdv; r && map |=> rd_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("no read answer");
  property p_err; (r || wr_en) && !map |=> addr_err; endproperty
  a_err: assert property (p_err) else $error("no addr error");
  property p_rw; wr_en && off == `RFA_OFF_CTRL |=>
    ctrl_out == ($past(wr_data) & `RFA_MASK_CTRL); endproperty
  a_rw: assert property (p_rw) else $error("ctrl wrong");
  property p_w1s; wr_en && off == `RFA_OFF_SETREQ |=> set_req_out ==
    ($past(set_req_out) | $past(wr_data[EV_W-1:0])); endproperty
  a_w1s: assert property (p_w1s) else $error("set wrong");
  sequence s_clr;
    pending_out == (($past(pending_out) & ~$past(wr_data[EV_W-1:0]))
      | $past(hw_event));
  endsequence
  property p_w1c; wr_en && off == `RFA_OFF_RIS |=> s_clr; endproperty
  a_w1c: assert property (p_w1c) else $error("ris wrong");
  property p_iclr; wr_en && off == `RFA_OFF_ICLR |=> s_clr; endproperty
  a_iclr: assert property (p_iclr) else $error("iclr wrong");
  property p_st; r && off == `RFA_OFF_STATUS |=>
    rd_data == {24'h0, $past(hw_status)}; endproperty
  a_st: assert property (p_st) else $error("status wrong");
  property p_rsv; rd_valid |-> rd_data[31:16] == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  c_rc: cover property (r && off == `RFA_OFF_EVCOUNT);
  c_w1c: cover property (wr_en && off == `RFA_OFF_RIS);
  c_err: cover property (addr_err);
endmodule
bind rfa_bank rfa_chk #(.BASE_ADDR(BASE_ADDR), .EV_W(EV_W)) chk_u (.*);

// ===== bench/tb.sv
// self-checking bench for rfa_bank
// assumes rfa_chk is bound for assertions
`timescale 1ns/1ps
`include "rfa_regs.svh"
module tb;
  import rfa_pkg::*;
  localparam logic [31:0] B = 32'h4000_0000;
  logic ref_clk = 0, reset = 1, wr_en = 0, rd_en = 0, inc = 0;
  logic rd_valid, addr_err, ae;
  logic [31:0] addr = B, ctrl_out;
  rfa_word_t wr_data = 0, rd_data, q;
  logic [7:0] st = 0, er = 0, ev = 0, sr, pd;
  int fails = 0, tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  rfa_bank #(.BASE_ADDR(B), .EV_W(8)) dut_u (.ref_clk(ref_clk),
    .reset(reset), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .addr_err(addr_err), .hw_status(st), .hw_count_inc(inc),
    .hw_error(er), .hw_event(ev), .ctrl_out(ctrl_out),
    .set_req_out(sr), .pending_out(pd));
  task chk(string n, rfa_word_t s, rfa_word_t e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task acc(bit w, logic [11:0] o, rfa_word_t d);
    @(posedge ref_clk);
    #1 addr = B + o;
    wr_en = w;
    rd_en = !w;
    wr_data = d;
    @(posedge ref_clk);
    #1 wr_en = 0;
    rd_en = 0;
    q = rd_data;
    ae = addr_err;
  endtask
  task automatic pulse(ref logic [7:0] s, input logic [7:0] v);
    s = v;
    @(posedge ref_clk);
    #1 s = 0;
  endtask
  task s_rw_ro;
    st = 8'h5a;
    acc(1, `RFA_OFF_CTRL, 32'hffff_a5a5);
    acc(1, `RFA_OFF_STATUS, 0);
    acc(0, `RFA_OFF_CTRL, 0);
    chk("ctrl", q, 32'hffff_a5a5 & `RFA_MASK_CTRL);
    acc(1, `RFA_OFF_CTRL, q ^ 32'h0000_00ff);
    acc(0, `RFA_OFF_CTRL, 0);
    chk("ctrl rmw", q, 32'h0000_a55a);
    acc(0, `RFA_OFF_STATUS, 0);
    chk("status", q, 32'h5a);
  endtask
  task s_rc_rwc;
    inc = 1;
    pulse(er, 8'h81);
    repeat (2) @(posedge ref_clk);
    #1 inc = 0;
    acc(0, `RFA_OFF_EVCOUNT, 0);
    chk("count", q, 3);
    acc(0, `RFA_OFF_EVCOUNT, 0);
    chk("count clr", q, 0);
    acc(0, `RFA_OFF_ERRLOG, 0);
    chk("errlog", q, 32'h81);
    acc(1, `RFA_OFF_ERRLOG, 0);
    acc(0, `RFA_OFF_ERRLOG, 0);
    chk("errlog clr", q, 0);
  endtask
  task s_w1c;
    pulse(ev, 8'h0f);
    acc(0, `RFA_OFF_RIS, 0);
    pulse(ev, 8'h30);
    acc(1, `RFA_OFF_RIS, q);
    acc(0, `RFA_OFF_RIS, 0);
    chk("ris", q, 32'h30);
    acc(1, `RFA_OFF_ICLR, 32'h10);
    acc(0, `RFA_OFF_ICLR, 0);
    chk("ris out", pd, 8'h20);
  endtask
  task s_w1s_bad;
    acc(1, `RFA_OFF_SETREQ, 32'h3);
    acc(1, `RFA_OFF_SETREQ, 32'hc);
    acc(1, `RFA_OFF_SETREQ, 0);
    acc(0, `RFA_OFF_SETREQ, 0);
    chk("setreq", q, 32'hf);
    acc(0, 12'h100, 0);
    chk("addr_err", ae, 1);
    chk("unmapped", q, 0);
  endtask
  task print_verdict;
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 reset = 0;
    s_rw_ro;
    s_rc_rwc;
    s_w1c;
    s_w1s_bad;
    print_verdict;
  end
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
endmodule
